// >>> bench/pdam_props.sv
// Concurrent checks on the link wires between controller and device
`timescale 1ns/1ps
module pdam_props import pdam_pkg::*; (
   input wire logic            clock,
   input wire logic            rst_n,
   input wire logic            ck,
   input wire logic            cs_n,
   input wire logic            mrs_n,
   input wire logic [BA_W-1:0] ba,
   input wire logic [MR_W-1:0] addr,
   input wire logic            dqs,
   input wire logic [DQ_W-1:0] dq
);
   typedef struct packed {
      logic       cs_q;
      logic       dqs_q;
      logic       pdam_on;
      logic       prev_on;
      logic [2:0] plf;
      logic [2:0] rises;
      logic [9:0] gap;
   } pdam_watch_t;

   pdam_watch_t w;
   pdam_watch_t next_w;
   logic        launch;
   int          pl;
   int          min_gap;

   // ---------------------------------------------------------------
   // Tracking
   // ---------------------------------------------------------------
   // Parity latency and minimum command spacing in clocks
   always_comb begin
      case (w.plf)
         3'h1: pl = 4;
         3'h2: pl = 5;
         3'h3: pl = 6;
         3'h4: pl = 8;
         default: pl = 0;
      endcase
      min_gap = 8 * (AL_CK + CWL_CK + MRD_QUAL_CK + pl + int'(w.rises)) - 4;
   end

   // Mode, burst and gap as seen on the wires
   assign launch = w.cs_q && !cs_n;
   always_comb begin
      next_w = w;
      next_w.cs_q = cs_n;
      next_w.dqs_q = dqs;
      if (w.gap != 10'h3FF)
         next_w.gap = w.gap + 10'h001;
      if (dqs && !w.dqs_q)
         next_w.rises = w.rises + 3'h1;
      if (launch) begin
         next_w.gap = 10'h001;
         next_w.rises = 3'h0;
         next_w.prev_on = w.pdam_on && !mrs_n;
         if (!mrs_n && dq == '0 && ba == MR3_SEL)
            next_w.pdam_on = addr[PDAM_BIT];
         if (!mrs_n && dq == '0 && ba == MR5_SEL)
            next_w.plf = addr[PL_LSB+2:PL_LSB];
      end
   end

   // Tracking register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n)
         w <= '{cs_q: 1'b1, default: '0};
      else
         w <= next_w;
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   chk_dq_uniform: assert property (dq == '0 || dq == '1)
      else $error("data bits disagree");
   chk_dq_steady: assert property ((dqs || $past(dqs)) |-> $stable(dq))
      else $error("qualifier moved in burst");
   chk_strobe_in_ck: assert property (dqs |-> ck)
      else $error("strobe high with link clock low");
   chk_burst_size: assert property (launch |-> w.rises inside {3'h0, 3'h2, 3'h4})
      else $error("bad burst length");
   chk_select_width: assert property ($fell(cs_n) |-> (!cs_n) [*8] ##1 cs_n)
      else $error("select width wrong");
   chk_launch_edge: assert property ($fell(cs_n) |-> $fell(ck))
      else $error("command off the clock fall");
   chk_ck_high_half: assert property ($rose(ck) |-> ck [*4] ##1 !ck)
      else $error("link clock high phase wrong");
   chk_quiet_strobe: assert property (!cs_n |-> !dqs)
      else $error("strobe during command");
   chk_exit_qual_low: assert property (launch && w.pdam_on && !mrs_n && ba == MR3_SEL
      && !addr[PDAM_BIT] |-> dq == '0)
      else $error("exit not qualified low");
   chk_mrs_only: assert property (launch && w.pdam_on |-> !mrs_n)
      else $error("other command in mode");
   chk_mode_spacing: assert property (launch && w.prev_on |-> int'(w.gap) >= min_gap)
      else $error("mode commands too close");
endmodule

// >>> bench/tb_top.sv
// Bench joining controller and device end to end over the link
`timescale 1ns/1ps
`define CHECK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin \
   errors++; $display("wrong value %s expected %h seen %h", what, exp, got); end end
module tb_top import pdam_pkg::*;;
   logic            clock = 1'b0;
   logic            rst_n = 1'b0;
   logic            req_valid;
   logic            req_mrs;
   logic [BA_W-1:0] req_ba;
   logic [MR_W-1:0] req_addr;
   logic            req_skip;
   logic            req_bc4;
   logic            leveling_done;
   logic            odt_level;
   logic            req_ready;
   logic            req_refused;
   logic            ctl_pdam;
   logic            dev_pdam;
   logic            mr_we;
   logic [BA_W-1:0] mr_wsel;
   logic [MR_W-1:0] mr_wdata;
   logic            discard;
   logic            illegal_cmd;
   pdam_rtt_t       rtt_mode;
   logic [18:0]     notes[$];
   logic [18:0]     note;
   logic [18:0]     seen;
   logic [BA_W-1:0] last_sel = 3'h0;
   logic [MR_W-1:0] last_data = 14'h0000;
   logic [31:0]     seed = 32'h0000001B;
   logic [2:0]      plc;
   int              errors = 0;
   int              comparisons = 0;

   // Bench clock
   always #(CLK_NS / 2) clock = ~clock;

   pdam_link_if link ();
   pdam_controller pdam_controller_inst (.clock(clock), .rst_n(rst_n), .link(link),
      .req_valid(req_valid), .req_mrs(req_mrs), .req_ba(req_ba), .req_addr(req_addr),
      .req_skip(req_skip), .req_bc4(req_bc4), .leveling_done(leveling_done),
      .odt_level(odt_level), .req_ready(req_ready), .req_refused(req_refused),
      .pdam_active(ctl_pdam));
   pdam_device pdam_device_inst (.clock(clock), .rst_n(rst_n), .link(link),
      .pdam_active(dev_pdam), .mr_we(mr_we), .mr_wsel(mr_wsel), .mr_wdata(mr_wdata),
      .discard(discard), .illegal_cmd(illegal_cmd), .rtt_mode(rtt_mode));
   pdam_props pdam_props_inst (.clock(clock), .rst_n(rst_n), .ck(link.ck),
      .cs_n(link.cs_n), .mrs_n(link.mrs_n), .ba(link.ba), .addr(link.addr),
      .dqs(link.dqs), .dq(link.dq));

   // Random source
   function automatic logic [31:0] rnd(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   // Verdict and end of run
   task automatic report_and_stop;
      if (errors == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // One request, its expected result noted first; kind 3 expects none
   task automatic issue(input logic m, input logic [BA_W-1:0] b, input logic [MR_W-1:0] a,
                        input logic s, input logic c, input logic [1:0] k);
      int n;
      if (k == 2'h0) begin
         last_sel = b;
         last_data = a;
      end
      if (k != 2'h3)
         notes.push_back({k, last_sel, last_data});
      @(posedge clock);
      req_valid <= 1'b1;
      req_mrs <= m;
      req_ba <= b;
      req_addr <= a;
      req_skip <= s;
      req_bc4 <= c;
      for (n = 0; n < 40 && req_ready && !req_refused; n++)
         @(negedge clock);
      // A request never taken counts as a mismatch
      if (n == 40)
         errors++;
      @(posedge clock);
      req_valid <= 1'b0;
      for (n = 0; n < 3000 && !(req_ready && notes.size() == 0); n++)
         @(negedge clock);
      // A result that never arrives counts as a mismatch
      if (n == 3000)
         errors++;
   endtask

   // Result watcher: oldest note against each result pulse
   always @(negedge clock) begin
      if (mr_we || discard || req_refused || illegal_cmd) begin
         note = (notes.size() > 0) ? notes.pop_front() : 19'h7FFFF;
         seen = {(illegal_cmd ? 2'h3 : req_refused ? 2'h2 : discard ? 2'h1 : 2'h0),
                 mr_wsel, mr_wdata};
         `CHECK("result", note, seen)
      end
   end

   // Main sequence
   initial begin
      req_valid = 1'b0;
      req_mrs = 1'b0;
      req_ba = 3'h0;
      req_addr = 14'h0000;
      req_skip = 1'b0;
      req_bc4 = 1'b0;
      leveling_done = 1'b0;
      odt_level = 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      `CHECK("mode at reset", 2'h0, {ctl_pdam, dev_pdam})
      `CHECK("termination at reset", PDAM_RTT_OFF, rtt_mode)
      issue(1'b0, 3'h0, 14'h0000, 1'b0, 1'b0, 2'h3);
      issue(1'b1, MR3_SEL, 14'h0010, 1'b0, 1'b0, 2'h2);
      @(posedge clock);
      leveling_done <= 1'b1;
      issue(1'b1, 3'h1, 14'h0100, 1'b0, 1'b0, 2'h0);
      for (plc = 3'h0; plc < 3'h5; plc++) begin
         seed = rnd(seed);
         @(posedge clock);
         odt_level <= seed[0];
         issue(1'b1, MR5_SEL, {11'h008, plc}, 1'b0, 1'b0, 2'h0);
         issue(1'b1, MR3_SEL, 14'h0010, 1'b0, seed[1], 2'h0);
         `CHECK("mode on", 2'h3, {ctl_pdam, dev_pdam})
         `CHECK("termination", seed[0] ? PDAM_RTT_NOM : PDAM_RTT_PARK, rtt_mode)
         issue(1'b1, 3'h6, seed[15:2], 1'b0, seed[16], 2'h0);
         issue(1'b1, 3'h6, seed[29:16], 1'b1, seed[17], 2'h1);
         issue(1'b0, 3'h0, 14'h0000, 1'b0, 1'b0, 2'h2);
         issue(1'b1, MR3_SEL, 14'h0000, 1'b1, seed[18], 2'h0);
         `CHECK("mode off", 2'h0, {ctl_pdam, dev_pdam})
         `CHECK("termination kept", seed[0] ? PDAM_RTT_NOM : PDAM_RTT_PARK, rtt_mode)
      end
      report_and_stop();
   end

   // Watchdog against a hang
   initial begin
      repeat (40000) @(posedge clock);
      errors++;
      report_and_stop();
   end
endmodule

// >>> src/pdam_controller.sv
// Controller end: issues mode register commands with the per-device qualifier
`timescale 1ns/1ps

module pdam_controller import pdam_pkg::*; (
   input  wire logic             clock,
   input  wire logic             rst_n,
   pdam_link_if.ctl              link,
   input  wire logic             req_valid,
   input  wire logic             req_mrs,
   input  wire logic [BA_W-1:0]  req_ba,
   input  wire logic [MR_W-1:0]  req_addr,
   input  wire logic             req_skip,
   input  wire logic             req_bc4,
   input  wire logic             leveling_done,
   input  wire logic             odt_level,
   output logic                  req_ready,
   output logic                  req_refused,
   output logic                  pdam_active
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef enum logic {CTL_IDLE, CTL_RUN} pdam_cst_t;

   typedef struct packed {
      logic [DIV_W-1:0] div;
      logic             ck;
      pdam_cst_t        st;
      logic [HW-1:0]    h;
      logic [HW-1:0]    lim;
      logic [HW-1:0]    b_lo;
      logic [HW-1:0]    b_hi;
      logic             pdam_on;
      logic [2:0]       pl;
      logic             rdy;
      logic             refused;
      logic             cs_n;
      logic             mrs_n;
      logic [BA_W-1:0]  ba;
      logic [MR_W-1:0]  addr;
      logic             dqs;
      logic [DQ_W-1:0]  dq;
      logic             odt;
   } pdam_cstate_t;

   pdam_cstate_t  q;
   pdam_cstate_t  n;
   logic          tick;
   logic          fall;
   logic          take;
   logic          is_mr3;
   logic          entry;
   logic          exit_cmd;
   logic          refuse;
   logic          applies;
   logic [HW-1:0] wl;
   logic [HW-1:0] bh;

   // ---------------------------------------------------------------
   // Request decode
   // ---------------------------------------------------------------

   // CK divider ticks and the half-period on which commands launch
   assign tick     = q.div == DIV_W'(CK_HALF_CYC - 1);
   assign fall     = tick & q.ck;
   assign take     = fall & req_valid & q.rdy & (q.st == CTL_IDLE);

   // Classify the request against the current mode
   assign is_mr3   = req_mrs && (req_ba == MR3_SEL);
   assign entry    = is_mr3 && req_addr[PDAM_BIT] && !q.pdam_on;
   assign exit_cmd = is_mr3 && !req_addr[PDAM_BIT] && q.pdam_on;
   assign refuse   = (entry && !leveling_done)
                   | (q.pdam_on && !req_mrs);

   // Every device of the rank applies the command unless it is skipped while the mode is on; an exit is never skipped
   assign applies  = req_mrs && (!q.pdam_on || !req_skip || exit_cmd);

   // Write latency including parity latency, and burst length in CK
   assign wl = HW'(AL_CK + CWL_CK) + HW'(pdam_pl_ck(q.pl));
   assign bh = req_bc4 ? HW'(BC4_CK) : HW'(BL8_CK);

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------

   // Half-CK counter h starts at 0 on the launching falling edge;
   // the device samples the command on the rise at h = 1.
   always_comb begin
      n         = q;
      n.refused = 1'b0;
      n.odt     = odt_level;
      n.div     = tick ? '0 : q.div + DIV_W'(1);
      n.ck      = q.ck ^ tick;
      unique case (q.st)
         CTL_IDLE: begin
            if (take) begin
               if (refuse) begin
                  n.refused = 1'b1;
               end else begin
                  n.st    = CTL_RUN;
                  n.rdy   = 1'b0;
                  n.h     = '0;
                  n.cs_n  = 1'b0;
                  n.mrs_n = ~req_mrs;
                  n.ba    = req_ba;
                  n.addr  = req_addr;
                  n.b_lo  = '0;
                  n.b_hi  = '0;
                  if (q.pdam_on && req_mrs) begin
                     // Every data bit carries the qualifier from launch to end
                     n.dq   = {DQ_W{req_skip && !exit_cmd}};
                     n.b_lo = HW'(1) + (wl << 1);
                     n.b_hi = HW'(1) + (wl << 1) + (bh << 1);
                     // Next launch at AL+CWL+BL/2-0.5+MRD+PL CK after the rise
                     n.lim  = ((wl + bh + HW'(MRD_QUAL_CK)) << 1) - HW'(2);
                  end else if (req_mrs) begin
                     n.dq   = '0;
                     // Device holds a plain write for the parity latency too
                     n.lim  = HW'(2 * MRD_CK - 2) + (HW'(pdam_pl_ck(q.pl)) << 1);
                  end else begin
                     n.dq   = '0;
                     n.lim  = HW'(2);
                  end
                  // Track the settings this end relies on
                  if (applies && req_ba == MR3_SEL) begin
                     n.pdam_on = req_addr[PDAM_BIT];
                  end
                  if (applies && req_ba == MR5_SEL) begin
                     n.pl = req_addr[PL_LSB +: 3];
                  end
               end
            end
         end
         CTL_RUN: begin
            if (tick) begin
               n.h = q.h + HW'(1);
               if (n.h == HW'(2)) begin
                  n.cs_n  = 1'b1;
                  n.mrs_n = 1'b1;
               end
               if (n.h >= q.lim) begin
                  n.st  = CTL_IDLE;
                  n.rdy = 1'b1;
                  n.dq  = '0;
               end
            end
         end
      endcase
      // Strobe follows CK inside the burst window only
      n.dqs = (n.st == CTL_RUN) && (n.h >= q.b_lo) && (n.h < q.b_hi) && n.ck;
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------

   // Reset leaves the link idle and the mode off
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         q       <= '0;
         q.cs_n  <= 1'b1;
         q.mrs_n <= 1'b1;
         q.rdy   <= 1'b1;
      end else begin
         q <= n;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------

   // Link pins straight from flops
   assign link.ck    = q.ck;
   assign link.cs_n  = q.cs_n;
   assign link.mrs_n = q.mrs_n;
   assign link.ba    = q.ba;
   assign link.addr  = q.addr;
   assign link.dqs   = q.dqs;
   assign link.dq    = q.dq;
   assign link.odt   = q.odt;

   // User-side status
   assign req_ready   = q.rdy;
   assign req_refused = q.refused;
   assign pdam_active = q.pdam_on;

endmodule

// >>> src/pdam_device.sv
// Memory device end: mode registers with per-device qualification
`timescale 1ns/1ps
module pdam_device import pdam_pkg::*; (
   input  wire logic        clock,
   input  wire logic        rst_n,
   pdam_link_if.dev         link,
   output logic             pdam_active,
   output logic             mr_we,
   output logic [BA_W-1:0]  mr_wsel,
   output logic [MR_W-1:0]  mr_wdata,
   output logic             discard,
   output logic             illegal_cmd,
   output pdam_rtt_t        rtt_mode
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {DEV_IDLE, DEV_PL, DEV_QUAL} pdam_dst_t;

   typedef struct packed {
      pdam_pins_t                   s1;
      pdam_pins_t                   s2;
      pdam_pins_t                   s3;
      pdam_pins_t                   f;
      pdam_pins_t                   fp;
      pdam_dst_t                    st;
      logic [5:0]                   cnt;
      logic [1:0]                   nrise;
      logic [BA_W-1:0]              sel;
      logic [MR_W-1:0]              val;
      logic [MR_NUM-1:0][MR_W-1:0]  mr;
      logic                         we;
      logic [BA_W-1:0]              wsel;
      logic [MR_W-1:0]              wdata;
      logic                         discard;
      logic                         illegal;
      pdam_rtt_t                    rtt;
   } pdam_dstate_t;

   pdam_dstate_t q;
   pdam_dstate_t n;
   pdam_pins_t   pins_in;
   pdam_pins_t   agree;
   logic         ck_rise;
   logic         dqs_rise;
   logic         pdam_on;
   logic [3:0]   pl;
   logic         do_write;

   // Link pins gathered for synchronising; only DQ0 is looked at
   assign pins_in  = {link.ck, link.cs_n, link.mrs_n, link.ba, link.addr,
                      link.dqs, link.dq[0], link.odt};
   assign agree    = ~(q.s2 ^ q.s3);
   assign ck_rise  = q.f.ck & ~q.fp.ck;
   assign dqs_rise = q.f.dqs & ~q.fp.dqs;
   assign pdam_on  = q.mr[MR3_IDX][PDAM_BIT];
   assign pl       = pdam_pl_ck(q.mr[MR5_IDX][PL_LSB +: 3]);

   // Next state
   always_comb begin
      n         = q;
      do_write  = 1'b0;
      n.we      = 1'b0;
      n.discard = 1'b0;
      n.illegal = 1'b0;
      n.s1      = pins_in;
      n.s2      = q.s1;
      n.s3      = q.s2;
      n.f       = (q.s2 & agree) | (q.f & ~agree);
      n.fp      = q.f;
      unique case (q.st)
         DEV_IDLE: begin
            if (ck_rise && !q.f.cs_n) begin
               if (!q.f.mrs_n) begin
                  n.sel = q.f.ba;
                  n.val = q.f.addr;
                  if (pl != 4'h0) begin
                     n.st  = DEV_PL;
                     n.cnt = 6'(pl);
                  end else if (pdam_on) begin
                     n.st    = DEV_QUAL;
                     n.cnt   = 6'(QUAL_TMO_CK);
                     n.nrise = 2'h0;
                  end else begin
                     do_write = 1'b1;
                  end
               end else if (pdam_on) begin
                  n.illegal = 1'b1;
               end
            end
         end
         DEV_PL: begin
            if (ck_rise) begin
               if (q.cnt == 6'h01) begin
                  if (pdam_on) begin
                     n.st    = DEV_QUAL;
                     n.cnt   = 6'(QUAL_TMO_CK);
                     n.nrise = 2'h0;
                  end else begin
                     n.st     = DEV_IDLE;
                     do_write = 1'b1;
                  end
               end else begin
                  n.cnt = q.cnt - 6'h01;
               end
            end
         end
         DEV_QUAL: begin
            // Qualifier taken on the second rising strobe edge
            if (dqs_rise) begin
               n.nrise = q.nrise + 2'h1;
               if (q.nrise == 2'h1) begin
                  n.st = DEV_IDLE;
                  if (q.f.dq0) begin
                     n.discard = 1'b1;
                  end else begin
                     do_write = 1'b1;
                  end
               end
            end else if (ck_rise) begin
               if (q.cnt == 6'h01) begin
                  n.st      = DEV_IDLE;
                  n.discard = 1'b1;
               end else begin
                  n.cnt = q.cnt - 6'h01;
               end
            end
         end
      endcase
      // Whole register rewritten; other registers keep their values
      if (do_write) begin
         n.we    = 1'b1;
         n.wsel  = n.sel;
         n.wdata = n.val;
         if (n.sel < BA_W'(MR_NUM)) begin
            n.mr[n.sel] = n.val;
         end
      end
      // Termination follows the ODT pin and the MR1 and MR5 fields: nominal, else park, else off
      if (q.f.odt && q.mr[MR1_IDX][NOM_LSB +: 3] != 3'h0) begin
         n.rtt = PDAM_RTT_NOM;
      end else if (q.mr[MR5_IDX][PARK_LSB +: 3] != 3'h0) begin
         n.rtt = PDAM_RTT_PARK;
      end else begin
         n.rtt = PDAM_RTT_OFF;
      end
   end

   // Registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         q    <= '0;
         q.s1 <= PINS_IDLE;
         q.s2 <= PINS_IDLE;
         q.s3 <= PINS_IDLE;
         q.f  <= PINS_IDLE;
         q.fp <= PINS_IDLE;
         q.mr <= {MR_NUM{MR_RESET}};
      end else begin
         q <= n;
      end
   end

   // Outputs
   assign pdam_active = q.mr[MR3_IDX][PDAM_BIT];
   assign mr_we       = q.we;
   assign mr_wsel     = q.wsel;
   assign mr_wdata    = q.wdata;
   assign discard     = q.discard;
   assign illegal_cmd = q.illegal;
   assign rtt_mode    = q.rtt;

endmodule

// >>> src/pdam_link_if.sv
// Command/address and data link between controller and memory device
`timescale 1ns/1ps
interface pdam_link_if import pdam_pkg::*; ();
   logic            ck;
   logic            cs_n;
   logic            mrs_n;
   logic [BA_W-1:0] ba;
   logic [MR_W-1:0] addr;
   logic            dqs;
   logic [DQ_W-1:0] dq;
   logic            odt;

   modport dev (input ck, cs_n, mrs_n, ba, addr, dqs, dq, odt);
   modport ctl (output ck, cs_n, mrs_n, ba, addr, dqs, dq, odt);
endinterface

// >>> src/pdam_pkg.sv
// Shared constants, types and helpers for the per-device mode register qualifier
package pdam_pkg;

   // ---------------------------------------------------------------
   // Clocking
   // ---------------------------------------------------------------
   localparam int CLK_NS       = 50;
   localparam int CK_PERIOD_NS = 400;
   localparam int CK_HALF_CYC  = CK_PERIOD_NS / (2 * CLK_NS);
   localparam int DIV_W        = 3;

   // ---------------------------------------------------------------
   // Widths
   // ---------------------------------------------------------------
   localparam int MR_NUM = 7;
   localparam int MR_W   = 14;
   localparam int BA_W   = 3;
   localparam int DQ_W   = 8;
   localparam int HW     = 8;

   // ---------------------------------------------------------------
   // Mode register selects and field positions
   // ---------------------------------------------------------------
   localparam logic [BA_W-1:0] MR3_SEL = 3'h3;
   localparam logic [BA_W-1:0] MR5_SEL = 3'h5;
   localparam int MR1_IDX  = 1;
   localparam int MR3_IDX  = 3;
   localparam int MR5_IDX  = 5;
   localparam int PDAM_BIT = 4;
   localparam int NOM_LSB  = 8;
   localparam int PARK_LSB = 6;
   localparam int PL_LSB   = 0;
   localparam logic [MR_W-1:0] MR_RESET = 14'h0000;

   // ---------------------------------------------------------------
   // Latencies in CK cycles
   // ---------------------------------------------------------------
   localparam int AL_CK       = 0;
   localparam int CWL_CK      = 9;
   localparam int MRD_QUAL_CK = 16;
   localparam int MRD_CK      = 8;
   localparam int BL8_CK      = 4;
   localparam int BC4_CK      = 2;
   localparam int QUAL_TMO_CK = 32;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {PDAM_RTT_OFF, PDAM_RTT_PARK, PDAM_RTT_NOM} pdam_rtt_t;

   typedef struct packed {
      logic            ck;
      logic            cs_n;
      logic            mrs_n;
      logic [BA_W-1:0] ba;
      logic [MR_W-1:0] addr;
      logic            dqs;
      logic            dq0;
      logic            odt;
   } pdam_pins_t;

   // Idle link: select and command strobes high, all else low
   localparam pdam_pins_t PINS_IDLE = 23'h300000;

   // Parity latency field decode into CK cycles
   function automatic logic [3:0] pdam_pl_ck(input logic [2:0] f);
      logic [3:0] r;
      r = 4'h0;
      case (f)
         3'h1: r = 4'h4;
         3'h2: r = 4'h5;
         3'h3: r = 4'h6;
         3'h4: r = 4'h8;
         default: r = 4'h0;
      endcase
      return r;
   endfunction

endpackage
